// [design/iwdg_top.v]
// independent watchdog with an AXI4-Lite register slave
// assumes the low-speed oscillator is asynchronous to i_clk and much slower than it
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "iwdg_defines.vh"

module iwdg_top #(
    parameter ADDR_W = 4
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_low_speed_osc_clock,
    input wire i_hw_autostart_option,
    input wire i_halt_run_option,
    input wire i_halt_mode,
    output wire o_watchdog_reset_out,
    output wire o_halt_wakeup,
    input wire [ADDR_W-1:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [ADDR_W-1:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready
);

    // last value of the prescaler count for a given field; code 111 falls back to /256
    function [7:0] iwdg_presc_last;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: iwdg_presc_last = 8'h03;
                3'h1: iwdg_presc_last = 8'h07;
                3'h2: iwdg_presc_last = 8'h0F;
                3'h3: iwdg_presc_last = 8'h1F;
                3'h4: iwdg_presc_last = 8'h3F;
                3'h5: iwdg_presc_last = 8'h7F;
                default: iwdg_presc_last = 8'hFF;
            endcase
        end
    endfunction

    // mapped only when the word offset's index is one of the four registers
    function iwdg_mapped;
        input [ADDR_W-1:0] addr;
        begin
            // with a four-bit address every offset is one of the four registers
            iwdg_mapped = ((addr >> 4) == {ADDR_W{1'b0}});
        end
    endfunction

    // strap slots in the option synchroniser and the edge on which autostart is judged
    localparam OPT_HW = 0;
    localparam OPT_RUN = 1;
    localparam N_OPT = 2;
    localparam [1:0] BOOT_CATCH = 2'h2;
    localparam [1:0] BOOT_LAST = 2'h3;

    reg [2:0] lsi_sync;
    reg [1:0] boot_cnt;
    reg running;
    reg unlocked;
    reg [2:0] prescale_field;
    reg [7:0] reload_field;
    reg [7:0] counter;
    reg [7:0] presc_cnt;
    reg expired;
    reg [1:0] tail_cnt;
    reg reset_out;
    reg wakeup;

    reg aw_held;
    reg [ADDR_W-1:0] aw_addr;
    reg w_held;
    reg [7:0] w_byte;
    reg w_lane0;

    wire lsi_edge;
    wire do_write;
    wire [1:0] w_idx;
    wire w_ok;
    wire key_wr;
    wire key_start;
    wire key_refresh;
    wire key_unlock;
    wire frozen;
    wire presc_tick;
    wire [N_OPT-1:0] opt_pins;
    wire [N_OPT-1:0] opt_sync;
    wire strap_catch;
    wire start_now;
    wire refresh_now;
    wire step_now;
    wire tail_done;
    wire [1:0] r_idx;
    reg [7:0] next_counter;
    reg [7:0] next_presc_cnt;
    reg [1:0] next_tail_cnt;
    reg [31:0] next_rdata;

    // lsi_sync[0] feeds only lsi_sync[1]; the edge is taken between the later stages
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lsi_sync <= 3'h0;
        end else begin
            lsi_sync <= {lsi_sync[1:0], i_low_speed_osc_clock};
        end
    end
    assign lsi_edge = lsi_sync[1] & ~lsi_sync[2];

    assign opt_pins = {i_halt_run_option, i_hw_autostart_option};

    // the option straps are asynchronous to i_clk, so each passes two flops before use
    genvar g;
    generate
        for (g = 0; g < N_OPT; g = g + 1) begin : g_opt_sync
            reg meta;
            reg held;
            always @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    meta <= 1'b0;
                    held <= 1'b0;
                end else begin
                    meta <= opt_pins[g];
                    held <= meta;
                end
            end
            assign opt_sync[g] = held;
        end
    endgenerate

    assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
    assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
    assign do_write = aw_held && w_held && !o_s_axi_bvalid;
    assign w_idx = aw_addr[3:2];
    assign w_ok = iwdg_mapped(aw_addr);

    assign key_wr = do_write && w_ok && w_lane0 && (w_idx == `IWDG_IDX_KEY);
    // any other key value falls through all three decodes
    assign key_start = key_wr && (w_byte == `IWDG_KEY_START);
    assign key_refresh = key_wr && (w_byte == `IWDG_KEY_REFRESH);
    assign key_unlock = key_wr && (w_byte == `IWDG_KEY_UNLOCK);

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `IWDG_RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= i_s_axi_wdata[7:0];
                w_lane0 <= i_s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= w_ok ? `IWDG_RESP_OKAY : `IWDG_RESP_SLVERR;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // protected registers and the unlock state
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            unlocked <= 1'b0;
            prescale_field <= `IWDG_PRESCALE_RESET;
            reload_field <= `IWDG_RELOAD_RESET;
        end else begin
            if (key_refresh) begin
                unlocked <= 1'b0;
            end else if (key_unlock) begin
                unlocked <= 1'b1;
            end
            if (do_write && w_ok && w_lane0 && unlocked) begin
                if (w_idx == `IWDG_IDX_PRESCALE) begin
                    prescale_field <= w_byte[2:0];
                end
                if (w_idx == `IWDG_IDX_RELOAD) begin
                    reload_field <= w_byte;
                end
            end
        end
    end

    // halt without the run option freezes the prescaler and the count
    // a refresh is still honoured while frozen, so software can re-arm before leaving halt
    assign frozen = i_halt_mode && !opt_sync[OPT_RUN];
    assign start_now = key_start && !running;
    // refresh and an oscillator edge in one cycle: the refresh wins and the edge is dropped
    assign refresh_now = key_refresh && running && !reset_out;
    assign step_now = running && !reset_out && !refresh_now && !frozen && lsi_edge;
    assign presc_tick = step_now && !expired
        && (presc_cnt == iwdg_presc_last(prescale_field));
    // three more low-speed periods after the counted timeout
    assign tail_done = step_now && expired
        && (tail_cnt == `IWDG_EXTRA_LSI_PERIODS - 2'h1);

    // the strap chain needs two edges to fill, so autostart is judged on the third edge
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            boot_cnt <= 2'h0;
        end else if (boot_cnt != BOOT_LAST) begin
            boot_cnt <= boot_cnt + 2'h1;
        end
    end
    assign strap_catch = (boot_cnt == BOOT_CATCH) && opt_sync[OPT_HW];

    // once started only i_arst_n clears running; a second start key is ignored
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            running <= 1'b0;
        end else if (strap_catch || start_now) begin
            running <= 1'b1;
        end
    end

    always @* begin
        next_presc_cnt = presc_cnt;
        if (start_now || refresh_now || presc_tick) begin
            // restarting the prescaler makes the timeout exact from the refresh
            next_presc_cnt = 8'h00;
        end else if (step_now && !expired) begin
            next_presc_cnt = presc_cnt + 8'h01;
        end
    end

    // the count stops at zero; expiry is then a separate flag
    always @* begin
        next_counter = counter;
        if (start_now) begin
            next_counter = `IWDG_COUNT_START;
        end else if (refresh_now) begin
            next_counter = reload_field;
        end else if (presc_tick && (counter != `IWDG_COUNT_END)) begin
            next_counter = counter - 8'h01;
        end
    end

    // the tail counts raw low-speed edges, not prescaled ticks
    always @* begin
        next_tail_cnt = tail_cnt;
        if (refresh_now) begin
            next_tail_cnt = 2'h0;
        end else if (step_now && expired) begin
            next_tail_cnt = tail_cnt + 2'h1;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            presc_cnt <= 8'h00;
            counter <= `IWDG_COUNT_START;
            tail_cnt <= 2'h0;
        end else begin
            presc_cnt <= next_presc_cnt;
            counter <= next_counter;
            tail_cnt <= next_tail_cnt;
        end
    end

    // expired is taken back by a refresh or i_arst_n, the reset only by i_arst_n; the wakeup is a one-cycle pulse
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            expired <= 1'b0;
            reset_out <= 1'b0;
            wakeup <= 1'b0;
        end else begin
            if (refresh_now) begin
                expired <= 1'b0;
            end else if (presc_tick && (counter == `IWDG_COUNT_END)) begin
                expired <= 1'b1;
            end
            if (tail_done) begin
                reset_out <= 1'b1;
            end
            wakeup <= tail_done && i_halt_mode;
        end
    end

    // the reset stays high until the system reset comes back around
    assign o_watchdog_reset_out = reset_out;
    assign o_halt_wakeup = wakeup;

    // one read at a time; the address is decoded in the cycle it is taken
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign r_idx = i_s_axi_araddr[3:2];

    always @* begin
        next_rdata = 32'h00000000;
        case (r_idx)
            `IWDG_IDX_PRESCALE: next_rdata[2:0] = prescale_field;
            `IWDG_IDX_RELOAD: next_rdata[7:0] = reload_field;
            `IWDG_IDX_STATUS: begin
                next_rdata[7:0] = counter;
                next_rdata[`IWDG_STAT_RUNNING] = running;
                next_rdata[`IWDG_STAT_UNLOCKED] = unlocked;
                next_rdata[`IWDG_STAT_RESET] = reset_out;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `IWDG_RESP_OKAY;
        end else begin
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                if (iwdg_mapped(i_s_axi_araddr)) begin
                    o_s_axi_rdata <= next_rdata;
                    o_s_axi_rresp <= `IWDG_RESP_OKAY;
                end else begin
                    o_s_axi_rdata <= 32'h00000000;
                    o_s_axi_rresp <= `IWDG_RESP_SLVERR;
                end
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // iwdg_top

// [shared/iwdg_defines.vh]
// register indices, field layout, key codes and reset values of the watchdog
// assumes a single system clock; the low-speed oscillator arrives as a sampled input
//
// Overview of operation
// - writing the start key launches the count-down from all ones.
// - the watchdog reset output is raised three low-speed periods after the running count has expired at zero.
// - writing the refresh key reloads the counter from the reload register.
// - prescale and reload registers ignore writes until the unlock key has been written.
// - the refresh key also withdraws the unlocked state of the protected registers.
// - with the hardware-start option set the watchdog runs straight out of reset.
// - the prescaler divides the low-speed clock by 2 to the power of field plus 2, at most 256.
// - the timeout spans prescaler divisor times reload value plus one low-speed periods.
// - the reset comes three low-speed periods after that timeout, counted from refresh.
// - the reload register is the value loaded on each refresh and counted down from.
// - the counter advances only on edges of the low-speed oscillator.
// - the halt-run option decides whether the counter keeps running while halted.
`ifndef IWDG_DEFINES_VH
`define IWDG_DEFINES_VH

`define IWDG_IDX_KEY 2'h0
`define IWDG_IDX_PRESCALE 2'h1
`define IWDG_IDX_RELOAD 2'h2
`define IWDG_IDX_STATUS 2'h3

`define IWDG_KEY_START 8'hCC
`define IWDG_KEY_REFRESH 8'hAA
`define IWDG_KEY_UNLOCK 8'h55

`define IWDG_PRESCALE_RESET 3'h0
`define IWDG_RELOAD_RESET 8'hFF
`define IWDG_COUNT_START 8'hFF
`define IWDG_COUNT_END 8'h00

`define IWDG_STAT_RUNNING 8
`define IWDG_STAT_UNLOCKED 9
`define IWDG_STAT_RESET 10

`define IWDG_EXTRA_LSI_PERIODS 2'h3

`define IWDG_RESP_OKAY 2'h0
`define IWDG_RESP_SLVERR 2'h2

`endif

// [verif/iwdg_checker.sv]
// concurrent checks on the watchdog top: bus handshakes, reset output, halt wakeup
// assumes one clock domain and the asynchronous active-low reset of the top
`timescale 1ns/1ps
`include "iwdg_defines.vh"
module iwdg_checker (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_halt_mode,
    input wire o_watchdog_reset_out,
    input wire o_halt_wakeup,
    input wire i_s_axi_awvalid,
    input wire o_s_axi_awready,
    input wire i_s_axi_wvalid,
    input wire o_s_axi_wready,
    input wire [1:0] o_s_axi_bresp,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire [31:0] o_s_axi_rdata,
    input wire [1:0] o_s_axi_rresp,
    input wire o_s_axi_rvalid,
    input wire i_s_axi_rready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_ar_take;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    sequence s_w_take;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    a_reset_sticky: assert property (o_watchdog_reset_out |=> o_watchdog_reset_out)
        else $error("watchdog reset dropped");
    a_wake_pulse: assert property (o_halt_wakeup |=> !o_halt_wakeup)
        else $error("wakeup longer than one cycle");
    a_wake_cause: assert property (o_halt_wakeup |-> $rose(o_watchdog_reset_out))
        else $error("wakeup without reset rise");
    a_wake_in_halt: assert property ($rose(o_watchdog_reset_out) && i_halt_mode |-> o_halt_wakeup)
        else $error("no wakeup for reset in halt");
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
        o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response not held");
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data not held");
    a_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken while answering");
    a_aw_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken while answering");
    a_write_answer: assert property (s_w_take |-> ##2 o_s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_ar_take |=>
        o_s_axi_rvalid && o_s_axi_rresp == `IWDG_RESP_OKAY) else $error("read response late");
endmodule // iwdg_checker
bind iwdg_top iwdg_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_halt_mode(i_halt_mode),
    .o_watchdog_reset_out(o_watchdog_reset_out), .o_halt_wakeup(o_halt_wakeup),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready));

// [verif/independent_watchdog_tb_top.sv]
// self-checking bench: registers over AXI4-Lite, key codes, timeouts, halt freeze
// assumes ADDR_W of 4; the low-speed clock is made here at 1/16 of i_clk
`timescale 1ns/1ps
`include "iwdg_defines.vh"
module independent_watchdog_tb_top;
    logic i_clk = 0, i_arst_n = 0, low_speed_osc_clock = 0, hw = 0, run = 0, halt = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, wdog_rst, wake;
    logic [1:0] bresp, rresp;
    int err_total = 0, n_checks = 0, n;
    always #4 i_clk = ~i_clk;
    iwdg_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_low_speed_osc_clock(low_speed_osc_clock),
        .i_hw_autostart_option(hw), .i_halt_run_option(run), .i_halt_mode(halt),
        .o_watchdog_reset_out(wdog_rst), .o_halt_wakeup(wake), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // byte address is four times the register index
    task automatic wr(input logic [1:0] idx, input logic [7:0] v);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, v};
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge i_clk);
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge i_clk); while (!bvalid);
        chk({30'h0, bresp}, {30'h0, `IWDG_RESP_OKAY});
        bready <= 0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [1:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do @(posedge i_clk); while (!arready);
        arvalid <= 0;
        do @(posedge i_clk); while (!rvalid);
        d = rdata;
        rready <= 0;
        @(posedge i_clk);
    endtask
    // edges are slow against i_clk so the two-flop sync latency has settled before we look
    task automatic count_to_reset(input int lim);
        n = 0;
        while (!wdog_rst && n < lim) begin
            repeat (8) @(posedge i_clk);
            low_speed_osc_clock <= 1;
            repeat (8) @(posedge i_clk);
            low_speed_osc_clock <= 0;
            n++;
        end
    endtask
    task automatic do_reset(input logic h);
        i_arst_n <= 0;
        hw <= h;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1;
        // the option straps need three edges after release before autostart is decided
        repeat (3) @(posedge i_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end
    initial begin
        do_reset(0);
        rd(`IWDG_IDX_PRESCALE); chk(d, 32'h00000000);
        rd(`IWDG_IDX_RELOAD); chk(d, 32'h000000FF);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000000FF);
        wr(`IWDG_IDX_RELOAD, 8'h00);
        rd(`IWDG_IDX_RELOAD); chk(d, 32'h000000FF);
        wr(`IWDG_IDX_KEY, `IWDG_KEY_START);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000001FF);
        wr(`IWDG_IDX_KEY, 8'h12);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000001FF);
        wr(`IWDG_IDX_KEY, `IWDG_KEY_UNLOCK);
        wr(`IWDG_IDX_KEY, 8'h33);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000003FF);
        wr(`IWDG_IDX_KEY, `IWDG_KEY_REFRESH);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000001FF);
        halt <= 1;
        // twenty oscillator periods would take five counts off if the freeze failed
        count_to_reset(20);
        chk(n, 20);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000001FF);
        run <= 1;
        for (int f = 0; f < 3; f++) begin
            halt <= (f == 2);
            do_reset(0);
            wr(`IWDG_IDX_KEY, `IWDG_KEY_START);
            wr(`IWDG_IDX_KEY, `IWDG_KEY_UNLOCK);
            wr(`IWDG_IDX_PRESCALE, f[7:0]);
            wr(`IWDG_IDX_RELOAD, 8'h00);
            wr(`IWDG_IDX_KEY, `IWDG_KEY_REFRESH);
            rd(`IWDG_IDX_PRESCALE); chk(d, f);
            count_to_reset(2000);
            chk(n, (4 << f) + 3);
        end
        halt <= 0;
        do_reset(1);
        rd(`IWDG_IDX_STATUS); chk({31'h0, d[8]}, 32'h00000001);
        count_to_reset(300);
        rd(`IWDG_IDX_STATUS); chk(d, 32'h000001B4);
        wr(`IWDG_IDX_KEY, `IWDG_KEY_REFRESH);
        chk({31'h0, wdog_rst}, 32'h00000000);
        count_to_reset(2000);
        chk(n, 4 * 256 + 3);
        print_verdict();
    end
endmodule // independent_watchdog_tb_top
